// ### core/pfw_regs.svh
`ifndef PFW_REGS_SVH
`define PFW_REGS_SVH
`define PFW_CLK_NS 4
`define PFW_PAGE_BYTES 128
`define PFW_PAGE_LSB 7
// Bus timing in ns, least figures
`define PFW_TWP_NS 70
`define PFW_TWPH_NS 150
`define PFW_TACC_NS 150
`define PFW_TWP_CYC ((`PFW_TWP_NS + `PFW_CLK_NS - 1) / `PFW_CLK_NS)
`define PFW_TWPH_CYC ((`PFW_TWPH_NS + `PFW_CLK_NS - 1) / `PFW_CLK_NS)
`define PFW_TACC_CYC ((`PFW_TACC_NS + `PFW_CLK_NS - 1) / `PFW_CLK_NS)
`define PFW_WR_CYC (`PFW_TWP_CYC + `PFW_TWPH_CYC + 2)
// Command pause in us
`define PFW_PAUSE_US 10
`define PFW_PAUSE_CYC ((`PFW_PAUSE_US * 1000 + `PFW_CLK_NS - 1) / `PFW_CLK_NS)
// Long times in us
`define PFW_BLW_US 200
`define PFW_BLCO_US 300
`define PFW_PROG_US 10000
`define PFW_ERASE_US 50000
// Command addresses and data
`define PFW_ADDR_5555 17'h05555
`define PFW_ADDR_2AAA 17'h02AAA
`define PFW_D_AA 8'hAA
`define PFW_D_55 8'h55
`define PFW_D_A0 8'hA0
`define PFW_D_80 8'h80
`define PFW_D_10 8'h10
`define PFW_D_60 8'h60
`define PFW_D_F0 8'hF0
// Sequence table slices: [start, end)
`define PFW_SEQ_PROT 5'h00
`define PFW_SEQ_ERASE 5'h03
`define PFW_SEQ_IDIN 5'h09
`define PFW_SEQ_IDOUT 5'h0F
`define PFW_SEQ_LAST 5'h12
`endif

// ### core/pfw_pkg.sv
`default_nettype none
package pfw_pkg;
	typedef enum logic [2:0] {
		OP_READ,
		OP_LOAD,
		OP_COMMIT,
		OP_ERASE,
		OP_ID_ENTER,
		OP_ID_EXIT,
		OP_HWID
	} pfw_op_t;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DISP,
		ST_WSET,
		ST_WLO,
		ST_WHI,
		ST_FIN,
		ST_RLO,
		ST_RHI,
		ST_PAUSE
	} pfw_state_t;
endpackage : pfw_pkg
`default_nettype wire

// ### core/pfw_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfw_regs.svh"
// Functional notes
// - Reads drive chip select and output gate low with write strobe high.
// - Host loads every byte of a page it wants to change.
// - Write cycle: chip select and write strobe low, output gate high.
// - Next byte load within 200 us keeps the page load phase open.
// - All bytes of one load phase share the page address.
// - A page load needs the AA, 55, A0 preamble first.
// - Hardware id: select, gate low, strobe high, overdrive on line 9.
// - Erase writes AA,55,80,AA,55,10 to 5555,2AAA,5555,5555,2AAA,5555.
// - Id entry ends with 60, exit is AA,55,F0; pause 10 us after.
module pfw_controller #(
	parameter int BLW_CYC = (`PFW_BLW_US * 1000) / `PFW_CLK_NS,
	parameter int BLCO_CYC = (`PFW_BLCO_US * 1000 + `PFW_CLK_NS - 1) / `PFW_CLK_NS,
	parameter int PROG_CYC = (`PFW_PROG_US * 1000) / `PFW_CLK_NS,
	parameter int ERASE_CYC = (`PFW_ERASE_US * 1000) / `PFW_CLK_NS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire pfw_pkg::pfw_op_t cmd_op,
	input wire logic [16:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output logic op_done,
	output logic op_error,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [16:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_i,
	output logic id_overdrive_en
);
	import pfw_pkg::*;

	localparam logic [23:0] WIN_LIM = 24'(BLW_CYC - `PFW_WR_CYC);
	localparam logic [23:0] BLCO_LIM = 24'(BLCO_CYC);
	localparam logic [23:0] PROG_LIM = 24'(PROG_CYC);
	localparam logic [23:0] ERASE_LIM = 24'(ERASE_CYC);
	localparam logic [11:0] TWP_C = 12'(`PFW_TWP_CYC - 1);
	localparam logic [11:0] TWPH_C = 12'(`PFW_TWPH_CYC - 1);
	localparam logic [11:0] TACC_C = 12'(`PFW_TACC_CYC - 1);
	localparam logic [11:0] PAUSE_C = 12'(`PFW_PAUSE_CYC - 1);

	// Command table: {address, data} per index
	function automatic logic [24:0] seq_word(input logic [4:0] idx);
		logic [16:0] a;
		logic [7:0] d;
		logic mid;
		mid = (5'(idx % 5'd3) == 5'd1);
		a = mid ? `PFW_ADDR_2AAA : `PFW_ADDR_5555;
		case (idx)
			5'h02: d = `PFW_D_A0;
			5'h05, 5'h0B: d = `PFW_D_80;
			5'h08: d = `PFW_D_10;
			5'h0E: d = `PFW_D_60;
			5'h11: d = `PFW_D_F0;
			default: d = mid ? `PFW_D_55 : `PFW_D_AA;
		endcase
		return {a, d};
	endfunction : seq_word

	pfw_state_t st_q;
	pfw_op_t op_q;
	logic [16:0] paddr_q, last_addr_q;
	logic [7:0] pdata_q;
	logic [4:0] seq_idx_q, seq_end_q;
	logic useq_q, poll_q, first_q, tog_q, stop_q, open_q, ready_q;
	logic [9:0] page_q;
	logic [23:0] gap_q, tmo_q, lim_q;
	logic [11:0] cnt_q;
	logic ce_n_q, oe_n_q, we_n_q, dq_oe_q, hv_q, done_q, err_q;
	logic [16:0] addr_q;
	logic [7:0] dq_o_q;
	logic out_v_q, sp_v_q;
	logic [7:0] out_q, sp_q;

	////////////////////////////////////////////////////////////////////////////
	// Decode
	wire take = cmd_valid && ready_q;
	wire direct_ok = open_q && cmd_op == OP_LOAD && cmd_addr[16:`PFW_PAGE_LSB] == page_q
		&& gap_q < WIN_LIM;
	wire cnt_end = cnt_q == 12'h000;
	wire [24:0] sw = seq_word(seq_idx_q);
	wire [16:0] wr_addr = useq_q ? sw[24:8] : paddr_q;
	wire [7:0] wr_data = useq_q ? sw[7:0] : pdata_q;
	wire [4:0] seq_nxt = seq_idx_q + 5'h01;
	wire tmo_hit = tmo_q >= lim_q;
	wire poll_stop = !first_q && flash_dq_i[6] == tog_q;
	wire push = st_q == ST_RLO && cnt_end && !poll_q;
	wire buf_full = out_v_q && sp_v_q;
	wire pop = out_v_q && rd_ready;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			op_q <= OP_READ;
			paddr_q <= 17'h00000;
			last_addr_q <= 17'h00000;
			pdata_q <= 8'h00;
			seq_idx_q <= 5'h00;
			seq_end_q <= 5'h00;
			useq_q <= 1'b0;
			poll_q <= 1'b0;
			first_q <= 1'b0;
			tog_q <= 1'b0;
			stop_q <= 1'b0;
			open_q <= 1'b0;
			ready_q <= 1'b0;
			page_q <= 10'h000;
			gap_q <= 24'h000000;
			tmo_q <= 24'h000000;
			lim_q <= 24'h000000;
			cnt_q <= 12'h000;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			dq_oe_q <= 1'b0;
			hv_q <= 1'b0;
			addr_q <= 17'h00000;
			dq_o_q <= 8'h00;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			err_q <= 1'b0;
			ready_q <= st_q == ST_IDLE && !take && !buf_full;
			gap_q <= (gap_q == 24'hFFFFFF) ? gap_q : gap_q + 24'h000001;
			tmo_q <= tmo_q + 24'h000001;
			cnt_q <= cnt_end ? cnt_q : cnt_q - 12'h001;
			case (st_q)
				ST_IDLE:
				begin
					if (take)
					begin
						op_q <= cmd_op;
						paddr_q <= cmd_addr;
						pdata_q <= cmd_data;
						st_q <= (open_q && !direct_ok) ? ST_FIN : ST_DISP;
					end
				end
				ST_DISP:
				begin
					useq_q <= 1'b1;
					st_q <= ST_WSET;
					case (op_q)
						OP_LOAD:
						begin
							useq_q <= !open_q;
							seq_idx_q <= `PFW_SEQ_PROT;
							seq_end_q <= `PFW_SEQ_ERASE;
						end
						OP_ERASE:
						begin
							seq_idx_q <= `PFW_SEQ_ERASE;
							seq_end_q <= `PFW_SEQ_IDIN;
						end
						OP_ID_ENTER:
						begin
							seq_idx_q <= `PFW_SEQ_IDIN;
							seq_end_q <= `PFW_SEQ_IDOUT;
						end
						OP_ID_EXIT:
						begin
							seq_idx_q <= `PFW_SEQ_IDOUT;
							seq_end_q <= `PFW_SEQ_LAST;
						end
						OP_READ, OP_HWID:
						begin
							hv_q <= op_q == OP_HWID;
							addr_q <= paddr_q;
							ce_n_q <= 1'b0;
							oe_n_q <= 1'b0;
							cnt_q <= TACC_C;
							st_q <= ST_RLO;
						end
						default:
						begin
							done_q <= 1'b1;
							st_q <= ST_IDLE;
						end
					endcase
				end
				ST_WSET:
				begin
					addr_q <= wr_addr;
					dq_o_q <= wr_data;
					dq_oe_q <= 1'b1;
					ce_n_q <= 1'b0;
					we_n_q <= 1'b0;
					cnt_q <= TWP_C;
					st_q <= ST_WLO;
				end
				ST_WLO:
				begin
					if (cnt_end)
					begin
						ce_n_q <= 1'b1;
						we_n_q <= 1'b1;
						cnt_q <= TWPH_C;
						st_q <= ST_WHI;
					end
				end
				ST_WHI:
				begin
					if (cnt_end)
					begin
						dq_oe_q <= 1'b0;
						if (useq_q && seq_nxt != seq_end_q)
						begin
							seq_idx_q <= seq_nxt;
							st_q <= ST_WSET;
						end
						else if (useq_q && op_q == OP_LOAD)
						begin
							useq_q <= 1'b0;
							st_q <= ST_WSET;
						end
						else if (useq_q && op_q == OP_ERASE)
						begin
							poll_q <= 1'b1;
							first_q <= 1'b1;
							tmo_q <= 24'h000000;
							lim_q <= ERASE_LIM;
							ce_n_q <= 1'b0;
							oe_n_q <= 1'b0;
							cnt_q <= TACC_C;
							st_q <= ST_RLO;
						end
						else if (useq_q)
						begin
							cnt_q <= PAUSE_C;
							st_q <= ST_PAUSE;
						end
						else
						begin
							open_q <= 1'b1;
							page_q <= paddr_q[16:`PFW_PAGE_LSB];
							last_addr_q <= paddr_q;
							gap_q <= 24'h000000;
							done_q <= 1'b1;
							st_q <= ST_IDLE;
						end
					end
				end
				ST_FIN:
				begin
					if (gap_q >= BLCO_LIM)
					begin
						open_q <= 1'b0;
						poll_q <= 1'b1;
						first_q <= 1'b1;
						tmo_q <= 24'h000000;
						lim_q <= PROG_LIM;
						addr_q <= last_addr_q;
						ce_n_q <= 1'b0;
						oe_n_q <= 1'b0;
						cnt_q <= TACC_C;
						st_q <= ST_RLO;
					end
				end
				ST_RLO:
				begin
					if (cnt_end)
					begin
						ce_n_q <= 1'b1;
						oe_n_q <= 1'b1;
						hv_q <= 1'b0;
						tog_q <= flash_dq_i[6];
						first_q <= 1'b0;
						stop_q <= poll_stop || tmo_hit;
						err_q <= poll_q && !poll_stop && tmo_hit;
						cnt_q <= TWPH_C;
						st_q <= ST_RHI;
					end
				end
				ST_RHI:
				begin
					if (cnt_end && (!poll_q || stop_q))
					begin
						poll_q <= 1'b0;
						done_q <= !poll_q || op_q == OP_ERASE;
						st_q <= (poll_q && op_q != OP_ERASE) ? ST_DISP : ST_IDLE;
					end
					else if (cnt_end)
					begin
						ce_n_q <= 1'b0;
						oe_n_q <= 1'b0;
						cnt_q <= TACC_C;
						st_q <= ST_RLO;
					end
				end
				ST_PAUSE:
				begin
					if (cnt_end)
					begin
						done_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-entry read buffer with registered head
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_v_q <= 1'b0;
			sp_v_q <= 1'b0;
			out_q <= 8'h00;
			sp_q <= 8'h00;
		end
		else if (pop || !out_v_q)
		begin
			out_v_q <= sp_v_q || push;
			out_q <= sp_v_q ? sp_q : flash_dq_i;
			sp_v_q <= sp_v_q && push;
			sp_q <= flash_dq_i;
		end
		else if (push)
		begin
			sp_v_q <= 1'b1;
			sp_q <= flash_dq_i;
		end
	end

	assign cmd_ready = ready_q;
	assign rd_valid = out_v_q;
	assign rd_data = out_q;
	assign op_done = done_q;
	assign op_error = err_q;
	assign flash_ce_n = ce_n_q;
	assign flash_oe_n = oe_n_q;
	assign flash_we_n = we_n_q;
	assign flash_addr = addr_q;
	assign flash_dq_o = dq_o_q;
	assign flash_dq_oe = dq_oe_q;
	assign id_overdrive_en = hv_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [7:0] last_wr_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			last_wr_q <= 8'h00;
		else if (!flash_we_n)
			last_wr_q <= flash_dq_o;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_pause_start;
		st_q == ST_PAUSE && $past(st_q) != ST_PAUSE;
	endsequence
	sequence s_pause_quiet;
		(st_q == ST_PAUSE && flash_ce_n && flash_we_n)[*8];
	endsequence

	a_read_strobes: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
		else $error("read strobes malformed");
	a_write_strobes: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write strobes malformed");
	a_we_pulse: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*8])
		else $error("write pulse too short");
	a_seq_words: assert property ($fell(flash_we_n) && useq_q
		|-> {flash_addr, flash_dq_o} == seq_word(seq_idx_q))
		else $error("command word wrong");
	a_same_page: assert property ($fell(flash_we_n) && !useq_q && open_q
		|-> flash_addr[16:7] == page_q)
		else $error("page address changed");
	a_load_window: assert property ($fell(flash_we_n) && !useq_q && open_q
		|-> gap_q < 24'(BLW_CYC))
		else $error("byte load too late");
	a_preamble_first: assert property ($fell(flash_we_n) && !useq_q && !open_q
		|-> last_wr_q == `PFW_D_A0)
		else $error("page load without preamble");
	a_pause_hold: assert property (s_pause_start |-> s_pause_quiet)
		else $error("pause cut short");
	a_hv_read: assert property (id_overdrive_en
		|-> !flash_ce_n && !flash_oe_n && flash_we_n)
		else $error("overdrive outside id read");
	a_fin_wait: assert property (st_q == ST_FIN && gap_q < BLCO_LIM |=> flash_ce_n)
		else $error("access before load timeout");
endmodule : pfw_controller
`default_nettype wire

// ### test/pfw_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module pfw_flash_model #(
	parameter int BLCO_NS = 2000,
	parameter int PROG_NS = 8000,
	parameter int ERASE_NS = 8000,
	// Identity codes are arbitrary
	parameter logic [7:0] MFR_CODE = 8'h3C,
	parameter logic [7:0] DEV_CODE = 8'h5A
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [16:0] addr,
	input wire logic [7:0] dq_in,
	input wire logic overdrive,
	output logic [7:0] dq_out,
	output logic dq_en
);
	logic [7:0] mem [int];
	logic [7:0] pbuf [128];
	logic [22:0] hist [6] = '{default: '0};
	logic [9:0] page = '0;
	logic [16:0] a_q = '0;
	logic [7:0] last_d = 8'h00;
	logic loading = 0;
	logic id_mode = 0;
	logic tog = 0;
	logic busy_q = 0;
	realtime t_fall = 0;
	realtime t_last = 0;
	wire sel_n = ce_n | we_n;
	wire rsel_n = ce_n | oe_n;
	assign dq_en = !ce_n && !oe_n && we_n;
	initial dq_out = 8'h00;
	////////////////////////////////////////////////////////////////
	function automatic bit hit(input int b, input logic [7:0] x);
		return hist[b + 2] == {15'h5555, 8'hAA} && hist[b + 1] == {15'h2AAA, 8'h55}
			&& hist[b] == {15'h5555, x};
	endfunction : hit
	task automatic run(input int t);
		busy_q = 1;
		fork
			#(t) busy_q = 0;
		join_none
	endtask : run
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		for (int i = 5; i > 0; i--)
			hist[i] = hist[i - 1];
		hist[0] = {a[14:0], d};
		t_last = $realtime;
		last_d = d;
		if (loading)
		begin
			page = a[16:7];
			pbuf[a[6:0]] = d;
		end
		else if (hit(3, 8'h80) && hit(0, 8'h10))
		begin
			mem.delete();
			run(ERASE_NS);
		end
		else if (hit(3, 8'h80) && hit(0, 8'h60))
			id_mode = 1;
		else if (hit(0, 8'hA0))
		begin
			loading = 1;
			foreach (pbuf[i])
				pbuf[i] = 8'hFF;
		end
		else if (hit(0, 8'hF0))
			id_mode = 0;
	endtask : wr
	////////////////////////////////////////////////////////////////
	always @(negedge sel_n)
		if (oe_n)
		begin
			a_q = addr;
			t_fall = $realtime;
		end
	always @(posedge sel_n)
		if (oe_n && !busy_q && $realtime - t_fall >= 15.0)
			wr(a_q, dq_in);
	initial
		forever
		begin
			#50;
			if (loading && $realtime - t_last >= BLCO_NS)
			begin
				loading = 0;
				for (int i = 0; i < 128; i++)
					mem[int'({page, i[6:0]})] = pbuf[i];
				run(PROG_NS);
			end
		end
	always @(negedge rsel_n)
		if (we_n)
		begin
			if (busy_q)
				tog = ~tog;
			#100;
			if (busy_q)
				dq_out = {~last_d[7], tog, last_d[5:0]};
			else if (id_mode || overdrive)
				dq_out = addr[0] ? DEV_CODE : MFR_CODE;
			else
				dq_out = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hFF;
		end
endmodule : pfw_flash_model
`default_nettype wire

// ### test/page_flash_write_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module page_flash_write_controller_bench;
	import pfw_pkg::*;
	localparam logic [7:0] MFR = 8'h3C;
	localparam logic [7:0] DEV = 8'h5A;
	logic sys_clk = 0, rst_n = 0, cmd_valid = 0, rd_ready = 0;
	pfw_op_t cmd_op = OP_READ;
	logic [16:0] cmd_addr = '0, fa;
	logic [7:0] cmd_data = '0, rd_data, dq_o, m_dq, dq_prev = 8'h00;
	logic cmd_ready, rd_valid, op_done, op_error, ce_n, oe_n, we_n, dq_oe, m_en, ovr;
	wire [7:0] dq_bus = dq_oe ? dq_o : (m_en ? m_dq : ~dq_prev);
	int seed = 34708, miscompares = 0, samples_checked = 0;
	logic [9:0] pg;
	logic [6:0] k1, k2;
	logic [7:0] d1, d2, d3;
	always @(posedge sys_clk)
		dq_prev <= dq_bus;
	initial
		forever
			#2 sys_clk = ~sys_clk;
	pfw_controller #(.BLW_CYC(400), .BLCO_CYC(600), .PROG_CYC(3000), .ERASE_CYC(3000)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .op_done(op_done), .op_error(op_error),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus), .id_overdrive_en(ovr));
	pfw_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(fa), .dq_in(dq_bus), .overdrive(ovr), .dq_out(m_dq), .dq_en(m_en));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] id_code(input logic a0);
		return a0 ? DEV : MFR;
	endfunction : id_code
	task automatic complete_run;
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic hang;
		miscompares++;
		$display("CHECK FAILED %0t wait limit used up", $time);
		complete_run();
	endtask : hang
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp1
	task automatic do_cmd(input pfw_op_t op, input logic [16:0] a, input logic [7:0] d);
		int n;
		logic err_seen;
		n = 0;
		err_seen = 1'b0;
		while (cmd_ready !== 1'b1)
		begin
			@(negedge sys_clk);
			if (++n > 30000)
				hang();
		end
		cmd_valid = 1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		@(negedge sys_clk);
		cmd_valid = 0;
		n = 0;
		// Error pulses come before the done pulse, so collect them while waiting
		while (op_done !== 1'b1)
		begin
			@(negedge sys_clk);
			err_seen = err_seen | op_error;
			if (++n > 30000)
				hang();
		end
		cmp1(err_seen, 1'b0);
	endtask : do_cmd
	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		while (rd_valid !== 1'b1)
		begin
			@(negedge sys_clk);
			if (++n > 100)
				hang();
		end
		cmp8(rd_data, exp);
		rd_ready = 1;
		@(negedge sys_clk);
		rd_ready = 0;
		@(negedge sys_clk);
	endtask : pop
	task automatic rd(input pfw_op_t op, input logic [16:0] a, input logic [7:0] exp);
		do_cmd(op, a, 8'h00);
		pop(exp);
	endtask : rd
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(negedge sys_clk);
		rst_n = 1;
		@(negedge sys_clk);
		repeat (3) rd(OP_READ, 17'($random(seed)), 8'hFF);
		pg = 10'($random(seed));
		k1 = 7'($random(seed));
		k2 = k1 ^ 7'h55;
		d1 = 8'($random(seed)) & 8'hFE;
		d2 = 8'($random(seed)) & 8'hFE;
		d3 = 8'($random(seed)) & 8'hFE;
		do_cmd(OP_LOAD, {pg, k1}, d1);
		do_cmd(OP_LOAD, {pg, k2}, d2);
		do_cmd(OP_COMMIT, {pg, k2}, 8'h00);
		rd(OP_READ, {pg, k1}, d1);
		rd(OP_READ, {pg, k2}, d2);
		do_cmd(OP_LOAD, {pg, k2}, d3);
		do_cmd(OP_COMMIT, {pg, k2}, 8'h00);
		rd(OP_READ, {pg, k1}, 8'hFF);
		rd(OP_READ, {pg, k2}, d3);
		// Two unread bytes fill the read buffer and hold off commands
		do_cmd(OP_READ, {pg, k2}, 8'h00);
		do_cmd(OP_READ, {pg, k1}, 8'h00);
		repeat (3) @(negedge sys_clk);
		cmp1(cmd_ready, 1'b0);
		pop(d3);
		pop(8'hFF);
		// A load to another page and a read while a page is open force programming first
		do_cmd(OP_LOAD, {pg ^ 10'h001, k1}, d1);
		do_cmd(OP_LOAD, {pg ^ 10'h002, k2}, d2);
		rd(OP_READ, {pg ^ 10'h001, k1}, d1);
		rd(OP_READ, {pg ^ 10'h002, k2}, d2);
		rd(OP_READ, {pg ^ 10'h002, k1}, 8'hFF);
		do_cmd(OP_ERASE, 17'h00000, 8'h00);
		rd(OP_READ, {pg, k2}, 8'hFF);
		do_cmd(OP_ID_ENTER, 17'h00000, 8'h00);
		rd(OP_READ, 17'h00000, id_code(1'b0));
		rd(OP_READ, 17'h00001, id_code(1'b1));
		do_cmd(OP_ID_EXIT, 17'h00000, 8'h00);
		rd(OP_READ, 17'h00001, 8'hFF);
		rd(OP_HWID, 17'h00001, id_code(1'b1));
		complete_run();
	end
endmodule : page_flash_write_controller_bench
`default_nettype wire
